/* File: core/fdsp_pkg.sv */
package fdsp_pkg;
    // serial modes, encoded as the two mode-select control bits
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_UART8 = 2'h1,
        MODE_UART9_FIXED = 2'h2,
        MODE_UART9_VAR = 2'h3
    } fdsp_mode_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SYNC = 2'h1,
        TX_RUN = 2'h3
    } fdsp_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } fdsp_rx_state_type;

    typedef struct packed {
        fdsp_mode_type mode;
        logic multiproc_enable;
        logic rx_enable;
        logic transmit_ninth_bit;
        logic rate_double;
    } fdsp_ctrl_type;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } fdsp_word_type;

    localparam int M0_DIV = 12;
    localparam int M2_SLOW_DIV = 64;
    localparam int M2_FAST_DIV = 32;
    localparam int OVERSAMPLE = 16;
    localparam int M2_SLOW_STEP = M2_SLOW_DIV / OVERSAMPLE;
    localparam int M2_FAST_STEP = M2_FAST_DIV / OVERSAMPLE;
    localparam int WORD_W = 9;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [3:0] SAMPLE_LAST = 4'hF;
    localparam logic [3:0] TX_LAST_8 = 4'h9;
    localparam logic [3:0] TX_LAST_9 = 4'hA;
    localparam logic [3:0] RX_LAST_8 = 4'h7;
    localparam logic [3:0] RX_LAST_9 = 4'h8;
    localparam logic [3:0] M0_LAST_BIT = 4'h7;
    localparam logic [10:0] TX_FRAME_RST = 11'h7FF;
    localparam logic [8:0] RX_SHIFT_RST = 9'h000;
endpackage : fdsp_pkg

/* File: core/fdsp_baud.sv */
`timescale 1ns/100ps
module fdsp_baud #(
    parameter int M0_DIV = fdsp_pkg::M0_DIV
) (
    input logic clk,
    input logic rst,
    input logic rate_double,
    output logic m0_bit,
    output logic m0_mid,
    output logic m0_low,
    output logic m2_samp
);
    import fdsp_pkg::*;
    localparam int CW = $clog2(M0_DIV);
    localparam int GW = CW + 1;
    logic [CW-1:0] m0_cnt_q;
    logic [1:0] m2_cnt_q;
    logic [1:0] m2_term;

    if (M0_DIV < 4 || (M0_DIV % 2) != 0) begin : g_chk
        $error("M0_DIV must be even and at least 4");
    end

    // free running, so a frame waits at most one bit time to align
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m0_cnt_q <= '0;
        end else begin
            m0_cnt_q <= m0_bit ? '0 : m0_cnt_q + 1'b1;
        end
    end
    assign m0_bit = (m0_cnt_q == CW'(M0_DIV - 1));
    assign m0_mid = (m0_cnt_q == CW'(M0_DIV / 2 - 1));
    assign m0_low = (m0_cnt_q < CW'(M0_DIV / 2));

    assign m2_term = rate_double ? 2'(M2_FAST_STEP - 1) : 2'(M2_SLOW_STEP - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m2_cnt_q <= 2'h0;
        end else begin
            m2_cnt_q <= m2_samp ? 2'h0 : m2_cnt_q + 2'h1;
        end
    end
    assign m2_samp = (m2_cnt_q >= m2_term);

    // cycles since the last shift strobe, held at its ceiling
    logic [GW-1:0] gap_q;
    logic seen_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else if (m0_bit) begin
            gap_q <= '0;
            seen_q <= 1'b1;
        end else if (gap_q != '1) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_m0_period;
        seen_q |-> (m0_bit ? gap_q == GW'(M0_DIV - 1) : gap_q < GW'(M0_DIV - 1));
    endproperty
    a_m0_period: assert property (p_m0_period) else $error("shift rate not 1/12");
    property p_m2_slow;
        (m2_samp && !rate_double) ##1 !rate_double [*4] |->
            m2_samp && !$past(m2_samp) && !$past(m2_samp, 2) && !$past(m2_samp, 3);
    endproperty
    a_m2_slow: assert property (p_m2_slow) else $error("slow mode 2 rate wrong");
endmodule : fdsp_baud

/* File: core/fdsp_fifo2.sv */
`timescale 1ns/100ps
module fdsp_fifo2 #(
    parameter int WIDTH = fdsp_pkg::WORD_W
) (
    input logic clk,
    input logic rst,
    input logic in_valid,
    input logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input logic out_ready
);
    logic [WIDTH-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    if (WIDTH < 1) begin : g_chk
        $error("WIDTH must be at least 1");
    end

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : fdsp_fifo2

/* File: core/fdsp_port.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - transmitter and receiver run independently, full duplex
// - receive is buffered; a byte completing with buffer full is lost
// - buffer write loads transmitter, buffer read returns separate receive data
// - mode 0 shifts 8 bits lsb first on data line, clock on output
// - mode 0 bit rate is fixed at clock/12
// - mode 1 frame: start 0, 8 data lsb first, stop 1
// - mode 1 receive stores stop bit as received ninth bit
// - modes 2/3 frame: start, 8 data, ninth from control, stop
// - modes 2/3 receive store ninth bit, stop bit not checked
// - mode 2 rate selectable clock/32 or clock/64
// - mode 3 equals mode 2 except variable rate
// - any buffer write starts a transmission in every mode
// - mode 0 receive starts when receive-done clear and receive enabled; the code also waits for buffer space and an idle transmitter
// - async receive starts on start bit only while receive enabled
// - multiprocessor modes 2/3: receive-done only if ninth bit is 1
// - mode bits 00/01/10/11 select modes 0/1/2/3
// - transmit-done set after 8th bit (mode 0) or at stop start
// - receive-done set after 8th bit (mode 0) or mid stop bit
// - mode 1 multiprocessor: receive-done only with valid stop bit
////////////////////////////////////////////////////////////////////////////////
module fdsp_port (
    input logic CLK,
    input logic RST,
    input fdsp_pkg::fdsp_ctrl_type CTRL,
    input logic BAUD_TICK,
    input logic WR_STB,
    input logic [7:0] WR_DATA,
    input logic RD_STB,
    output logic [7:0] RD_DATA,
    output logic RX_AVAIL,
    output logic RECEIVED_NINTH_BIT,
    output logic TX_DONE_FLAG,
    output logic RX_DONE_FLAG,
    input logic CLR_TX_DONE,
    input logic CLR_RX_DONE,
    input logic RXD_I,
    output logic RXD_O,
    output logic RXD_OE,
    output logic TXD
);
    import fdsp_pkg::*;

    fdsp_mode_type mode;
    logic async_mode, nine_bit, samp_tick;
    logic m0_bit, m0_mid, m0_low, m2_samp;
    fdsp_tx_state_type tx_state_q;
    logic [10:0] tx_frame_q;
    logic [3:0] tx_idx_q, tx_sub_q, tx_last;
    logic tx_m0_q, ti_set, m0_tx_run, m0_run;
    fdsp_rx_state_type rx_state_q;
    logic [8:0] rx_shift_q;
    logic [3:0] rx_idx_q, rx_sub_q, rx_last;
    logic rx_m0_q, rx_prev_q, m0_rx_go, m0_fin, stop_mid;
    logic rx_ninth, rx_accept, rx_fire, buf_ready;
    fdsp_word_type rx_word, head_word;
    logic txd_q, rxd_o_q, rxd_oe_q;

    // mode is read live, so it must not change mid-frame
    assign mode = CTRL.mode;
    assign async_mode = (mode != MODE_SHIFT);
    assign nine_bit = mode[1];
    assign samp_tick = (mode == MODE_UART9_FIXED) ? m2_samp : BAUD_TICK;

    fdsp_baud u_baud (
        .clk(CLK),
        .rst(RST),
        .rate_double(CTRL.rate_double),
        .m0_bit(m0_bit),
        .m0_mid(m0_mid),
        .m0_low(m0_low),
        .m2_samp(m2_samp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    assign tx_last = nine_bit ? TX_LAST_9 : TX_LAST_8;
    assign ti_set = (tx_state_q == TX_RUN) && (tx_m0_q ?
        (m0_bit && tx_idx_q == M0_LAST_BIT) :
        (samp_tick && tx_sub_q == SAMPLE_LAST && tx_idx_q == tx_last - 4'h1));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_state_q <= TX_IDLE;
            tx_frame_q <= TX_FRAME_RST;
            tx_idx_q <= 4'h0;
            tx_sub_q <= 4'h0;
            tx_m0_q <= 1'b0;
        end else if (WR_STB) begin
            // a write while busy restarts the frame with the new byte
            tx_frame_q <= async_mode ?
                {1'b1, nine_bit ? CTRL.transmit_ninth_bit : 1'b1, WR_DATA, 1'b0} :
                {3'h7, WR_DATA};
            tx_state_q <= async_mode ? TX_RUN : TX_SYNC;
            tx_m0_q <= !async_mode;
            tx_idx_q <= 4'h0;
            tx_sub_q <= 4'h0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    tx_idx_q <= 4'h0;
                end
                TX_SYNC: begin
                    if (m0_bit) begin
                        tx_state_q <= TX_RUN;
                    end
                end
                TX_RUN: begin
                    if (tx_m0_q) begin
                        if (m0_bit) begin
                            if (tx_idx_q == M0_LAST_BIT) begin
                                tx_state_q <= TX_IDLE;
                            end else begin
                                tx_idx_q <= tx_idx_q + 4'h1;
                            end
                        end
                    end else if (samp_tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == SAMPLE_LAST) begin
                            if (tx_idx_q == tx_last) begin
                                tx_state_q <= TX_IDLE;
                            end else begin
                                tx_idx_q <= tx_idx_q + 4'h1;
                            end
                        end
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    assign rx_last = nine_bit ? RX_LAST_9 : RX_LAST_8;
    // buf_ready stalls mode 0 reception instead of losing a byte
    assign m0_rx_go = !async_mode && CTRL.rx_enable && !RX_DONE_FLAG && buf_ready
        && tx_state_q == TX_IDLE;
    assign m0_fin = (rx_state_q == RX_DATA) && rx_m0_q && m0_bit && rx_idx_q == M0_LAST_BIT;
    assign stop_mid = (rx_state_q == RX_STOP) && samp_tick && rx_sub_q == SAMPLE_MID;
    // ninth bit, or the stop bit itself in mode 1
    assign rx_ninth = nine_bit ? rx_shift_q[8] : RXD_I;
    assign rx_accept = m0_fin || (stop_mid && !(CTRL.multiproc_enable && !rx_ninth));
    assign rx_fire = rx_accept && buf_ready;
    assign rx_word.ninth = m0_fin ? 1'b0 : rx_ninth;
    assign rx_word.data = rx_shift_q[7:0];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_prev_q <= 1'b1;
        end else if (samp_tick) begin
            rx_prev_q <= RXD_I;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_state_q <= RX_IDLE;
            rx_shift_q <= RX_SHIFT_RST;
            rx_idx_q <= 4'h0;
            rx_sub_q <= 4'h0;
            rx_m0_q <= 1'b0;
        end else begin
            case (rx_state_q)
                RX_IDLE: begin
                    rx_idx_q <= 4'h0;
                    rx_sub_q <= 4'h0;
                    if (m0_rx_go) begin
                        rx_state_q <= RX_START;
                        rx_m0_q <= 1'b1;
                    end else if (async_mode && samp_tick && CTRL.rx_enable
                                 && rx_prev_q && !RXD_I) begin
                        rx_state_q <= RX_START;
                        rx_m0_q <= 1'b0;
                    end
                end
                RX_START: begin
                    if (rx_m0_q) begin
                        if (m0_bit) begin
                            rx_state_q <= RX_DATA;
                        end
                    end else if (samp_tick) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        // a glitch shorter than half a bit is no start bit
                        if (rx_sub_q == SAMPLE_MID && RXD_I) begin
                            rx_state_q <= RX_IDLE;
                        end else if (rx_sub_q == SAMPLE_LAST) begin
                            rx_state_q <= RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_m0_q) begin
                        if (m0_mid) begin
                            rx_shift_q[rx_idx_q] <= RXD_I;
                        end
                        if (m0_bit) begin
                            if (rx_idx_q == M0_LAST_BIT) begin
                                rx_state_q <= RX_IDLE;
                            end else begin
                                rx_idx_q <= rx_idx_q + 4'h1;
                            end
                        end
                    end else if (samp_tick) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == SAMPLE_MID) begin
                            rx_shift_q[rx_idx_q] <= RXD_I;
                        end
                        if (rx_sub_q == SAMPLE_LAST) begin
                            if (rx_idx_q == rx_last) begin
                                rx_state_q <= RX_STOP;
                            end else begin
                                rx_idx_q <= rx_idx_q + 4'h1;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (samp_tick) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == SAMPLE_MID) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end

    fdsp_fifo2 #(.WIDTH(WORD_W)) u_rx_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(rx_accept),
        .in_data(rx_word),
        .in_ready(buf_ready),
        .out_valid(RX_AVAIL),
        .out_data(head_word),
        .out_ready(RD_STB)
    );
    assign RD_DATA = head_word.data;
    assign RECEIVED_NINTH_BIT = head_word.ninth;

    ////////////////////////////////////////////////////////////////////////////
    // flags: a set in the clearing cycle wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TX_DONE_FLAG <= 1'b0;
        end else if (ti_set) begin
            TX_DONE_FLAG <= 1'b1;
        end else if (CLR_TX_DONE) begin
            TX_DONE_FLAG <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RX_DONE_FLAG <= 1'b0;
        end else if (rx_fire) begin
            RX_DONE_FLAG <= 1'b1;
        end else if (CLR_RX_DONE) begin
            RX_DONE_FLAG <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    assign m0_tx_run = tx_m0_q && tx_state_q == TX_RUN;
    assign m0_run = m0_tx_run || (rx_m0_q && rx_state_q == RX_DATA);
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            txd_q <= 1'b1;
            rxd_o_q <= 1'b1;
            rxd_oe_q <= 1'b0;
        end else begin
            txd_q <= m0_run ? !m0_low :
                ((tx_state_q == TX_RUN) ? tx_frame_q[tx_idx_q] : 1'b1);
            rxd_o_q <= m0_tx_run ? tx_frame_q[tx_idx_q] : 1'b1;
            rxd_oe_q <= m0_tx_run;
        end
    end
    assign TXD = txd_q;
    assign RXD_O = rxd_o_q;
    assign RXD_OE = rxd_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_write_starts;
        WR_STB |=> tx_state_q != TX_IDLE;
    endproperty
    a_write_starts: assert property (p_write_starts) else $error("write did not start");
    property p_start_low;
        WR_STB && async_mode |=> ##1 (txd_q == 1'b0);
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit");
    property p_ninth_sent;
        WR_STB && nine_bit |=> tx_frame_q[9] == $past(CTRL.transmit_ninth_bit);
    endproperty
    a_ninth_sent: assert property (p_ninth_sent) else $error("ninth bit not loaded");
    property p_ti_at_stop;
        ti_set && !tx_m0_q |=> tx_idx_q == tx_last ##1 txd_q;
    endproperty
    a_ti_at_stop: assert property (p_ti_at_stop) else $error("tx done not at stop");
    property p_m0_rx_start;
        $rose(rx_state_q == RX_START) && rx_m0_q |-> $past(!RX_DONE_FLAG && CTRL.rx_enable);
    endproperty
    a_m0_rx_start: assert property (p_m0_rx_start) else $error("bad mode 0 rx start");
    property p_async_rx_start;
        $rose(rx_state_q == RX_START) && !rx_m0_q |-> $past(CTRL.rx_enable && !RXD_I);
    endproperty
    a_async_rx_start: assert property (p_async_rx_start) else $error("bad rx start");
    property p_mp_filter;
        rx_fire && nine_bit && CTRL.multiproc_enable |-> rx_word.ninth;
    endproperty
    a_mp_filter: assert property (p_mp_filter) else $error("address filter leak");
    property p_stop_check;
        stop_mid && mode == MODE_UART8 && CTRL.multiproc_enable && !RXD_I
            |=> !$rose(RX_DONE_FLAG);
    endproperty
    a_stop_check: assert property (p_stop_check) else $error("bad stop accepted");
    property p_read_separate;
        WR_STB && !RD_STB && !rx_fire |=> $stable(RD_DATA);
    endproperty
    a_read_separate: assert property (p_read_separate) else $error("write hit rx data");
    property p_rx_flag;
        rx_fire |=> RX_DONE_FLAG ##1 (RX_DONE_FLAG || $past(CLR_RX_DONE));
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("rx done lost");
    c_async_tx: cover property ($rose(TX_DONE_FLAG) && async_mode);
    c_m0_rx: cover property (rx_fire && rx_m0_q);
    c_duplex: cover property (tx_state_q == TX_RUN && rx_state_q == RX_DATA && async_mode);
    c_lost: cover property (rx_accept && !buf_ready);
endmodule : fdsp_port

/* File: verification/fdsp_remote.sv */
`timescale 1ns/100ps
module fdsp_remote (
    input logic clk,
    input logic txd,
    input logic line,
    output logic rx_line
);
    realtime t0;

    // idle async line sits high between frames
    initial rx_line = 1'b1;

    task automatic send(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rx_line = f[i];
            repeat (per) @(negedge clk);
        end
        rx_line = 1'b1;
    endtask : send

    // mid-bit sampling tolerates the short first bit of the port
    task automatic grab(output logic [10:0] f, input int n, input int per);
        f = 11'h000;
        @(negedge txd);
        repeat (per / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (per) @(negedge clk);
        end
    endtask : grab

    task automatic m0_grab(output logic [7:0] b, output int cyc);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            b[i] = line;
            if (i == 0) t0 = $realtime;
            if (i == 1) cyc = int'(($realtime - t0) / 50.0);
        end
    endtask : m0_grab

    // next bit presented only after the rising shift clock
    task automatic m0_feed(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rx_line = b[i];
            @(posedge txd);
            @(negedge clk);
        end
        // released: no longer holds the last bit
        rx_line = ~b[7];
    endtask : m0_feed
endmodule : fdsp_remote

/* File: verification/tb_full_duplex_serial_port.sv */
`timescale 1ns/100ps
module tb_full_duplex_serial_port;
    import fdsp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fdsp_ctrl_type ctrl = '0;
    logic tick = 1'b0;
    logic wr_stb = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic rd_stb = 1'b0;
    logic clr_tx = 1'b0;
    logic clr_rx = 1'b0;
    logic [7:0] rd_data;
    logic avail, ninth, tx_done, rx_done, rxd_o, rxd_oe, txd, rem_line;
    logic [10:0] f;
    logic [7:0] b;
    int cyc;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int div = 0;
    // shared data pin: the port wins while its shift driver is on
    wire rxd_line = rxd_oe ? rxd_o : rem_line;

    always #25 clk = ~clk;

    // oversample tick every 4 cycles, so 64 cycles a bit
    always @(negedge clk) begin
        div <= (div + 1) % 4;
        tick <= (div == 3);
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            stop_test();
        end
    end

    fdsp_port u_dut (
        .CLK(clk),
        .RST(rst),
        .CTRL(ctrl),
        .BAUD_TICK(tick),
        .WR_STB(wr_stb),
        .WR_DATA(wr_data),
        .RD_STB(rd_stb),
        .RD_DATA(rd_data),
        .RX_AVAIL(avail),
        .RECEIVED_NINTH_BIT(ninth),
        .TX_DONE_FLAG(tx_done),
        .RX_DONE_FLAG(rx_done),
        .CLR_TX_DONE(clr_tx),
        .CLR_RX_DONE(clr_rx),
        .RXD_I(rxd_line),
        .RXD_O(rxd_o),
        .RXD_OE(rxd_oe),
        .TXD(txd)
    );

    fdsp_remote u_remote (
        .clk(clk),
        .txd(txd),
        .line(rxd_line),
        .rx_line(rem_line)
    );

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic setm(input fdsp_mode_type m, input logic mp, input logic ren,
            input logic n9, input logic dbl);
        @(negedge clk);
        ctrl = {m, mp, ren, n9, dbl};
        clr_tx = 1'b1;
        clr_rx = 1'b1;
        @(negedge clk);
        clr_tx = 1'b0;
        clr_rx = 1'b0;
    endtask : setm

    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        wr_data = d;
        wr_stb = 1'b1;
        @(negedge clk);
        wr_stb = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] d, input logic n9);
        chk("rx avail", 11'h001, avail);
        chk("rx data", d, rd_data);
        chk("rx ninth", n9, ninth);
        @(negedge clk);
        rd_stb = 1'b1;
        @(negedge clk);
        rd_stb = 1'b0;
    endtask : rd

    task automatic t_reset();
        chk("txd idle", 11'h001, txd);
        chk("data drive", 11'h000, rxd_oe);
        chk("tx done", 11'h000, tx_done);
        chk("rx done", 11'h000, rx_done);
        chk("rx avail", 11'h000, avail);
    endtask : t_reset

    // both directions at once; mode 1 frames carry n9 as their stop bit
    task automatic t_duplex(input fdsp_mode_type m, input logic dbl, input logic n9,
            input logic stop, input logic [7:0] d);
        int per;
        int n;
        logic [10:0] exp;
        per = (m == MODE_UART9_FIXED && dbl) ? 32 : 64;
        n = (m == MODE_UART8) ? 10 : 11;
        exp = (m == MODE_UART8) ? {2'h1, d, 1'h0} : {1'h1, n9, d, 1'h0};
        setm(m, 1'h0, 1'h1, n9, dbl);
        fork
            u_remote.send({stop, n9, ~d, 1'h0}, n, per);
            u_remote.grab(f, n, per);
            wr(d);
        join
        chk("tx frame", exp, f);
        chk("tx done", 11'h001, tx_done);
        for (int i = 0; i < 1000 && rx_done !== 1'b1; i++) @(negedge clk);
        chk("rx done", 11'h001, rx_done);
        rd(~d, n9);
    endtask : t_duplex

    task automatic t_rx(input fdsp_mode_type m, input logic mp, input logic ren,
            input logic n9, input logic stop, input logic ok);
        setm(m, mp, ren, 1'h0, 1'h0);
        u_remote.send({stop, n9, 8'h69, 1'h0}, (m == MODE_UART8) ? 10 : 11, 64);
        repeat (64) @(negedge clk);
        chk("rx done", ok, rx_done);
        chk("rx avail", ok, avail);
        if (ok) rd(8'h69, n9);
    endtask : t_rx

    // three frames unread: the third has nowhere to go
    task automatic t_overrun();
        setm(MODE_UART8, 1'h0, 1'h1, 1'h0, 1'h0);
        u_remote.send({2'h3, 8'h11, 1'h0}, 10, 64);
        u_remote.send({2'h3, 8'h22, 1'h0}, 10, 64);
        u_remote.send({2'h3, 8'h33, 1'h0}, 10, 64);
        repeat (64) @(negedge clk);
        rd(8'h11, 1'h1);
        rd(8'h22, 1'h1);
        chk("rx avail", 11'h000, avail);
    endtask : t_overrun

    task automatic t_m0_tx();
        setm(MODE_SHIFT, 1'h0, 1'h0, 1'h0, 1'h0);
        // control untouched until the shift is over, to keep the pins clean
        fork
            u_remote.m0_grab(b, cyc);
            wr(8'h3C);
        join
        chk("shift data", 8'h3C, b);
        chk("shift bit cycles", 11'h00C, 11'(cyc));
        repeat (8) @(negedge clk);
        chk("tx done", 11'h001, tx_done);
    endtask : t_m0_tx

    task automatic t_m0_rx();
        setm(MODE_SHIFT, 1'h0, 1'h0, 1'h0, 1'h0);
        fork
            u_remote.m0_feed(8'hB4);
            begin
                @(negedge clk);
                ctrl.rx_enable = 1'h1;
            end
        join
        for (int i = 0; i < 1000 && rx_done !== 1'b1; i++) @(negedge clk);
        repeat (150) @(negedge clk);
        rd(8'hB4, 1'h0);
        chk("rx avail", 11'h000, avail);
        ctrl.rx_enable = 1'h0;
    endtask : t_m0_rx

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_duplex(MODE_UART8, 1'h0, 1'h1, 1'h1, 8'hA5);
        t_duplex(MODE_UART9_FIXED, 1'h0, 1'h0, 1'h1, 8'hC3);
        t_duplex(MODE_UART9_FIXED, 1'h1, 1'h1, 1'h0, 8'h5A);
        t_duplex(MODE_UART9_VAR, 1'h0, 1'h1, 1'h1, 8'h81);
        t_rx(MODE_UART8, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        t_rx(MODE_UART9_VAR, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        t_rx(MODE_UART9_VAR, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
        t_rx(MODE_UART8, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        t_rx(MODE_UART8, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
        t_overrun();
        t_m0_tx();
        t_m0_rx();
        stop_test();
    end
endmodule : tb_full_duplex_serial_port
